// >>> include/pin_ctl_pkg.sv
package pin_ctl_pkg;

    // ==========================================================
    // Register port geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int NUM_PINS = 7;

    // ==========================================================
    // Register offsets
    localparam logic [5:0] ADDR_SW_RESET = 6'h00;
    localparam logic [5:0] ADDR_DOZE_CLOCK_CONTROL = 6'h07;
    localparam logic [5:0] ADDR_MISC_CONTROL = 6'h09;
    localparam logic [5:0] ADDR_CLOCK_OUT_CONTROL = 6'h0a;
    localparam logic [5:0] ADDR_PIN_DIRECTION = 6'h0b;
    localparam logic [5:0] ADDR_PIN_OUTPUT_VALUE = 6'h0c;
    localparam logic [5:0] ADDR_IRQ_STATUS = 6'h24;
    localparam logic [5:0] ADDR_PIN_INPUT_VALUE = 6'h28;

    // ==========================================================
    // Field positions
    localparam int HIBERNATE_REQ_BIT = 0;
    localparam int DOZE_REQ_BIT = 1;
    localparam int KEEP_IN_DOZE_BIT = 9;
    localparam int CLKO_EN_BIT = 5;
    localparam int STATUS_PIN_SEL_BIT = 7;
    localparam int CLKO_RATE_LSB = 0;
    localparam int XTAL_TRIM_LSB = 8;
    localparam int PIN_OEN_LSB = 0;
    localparam int LOW_GROUP_DRIVE_LSB = 7;
    localparam int PIN_IEN_LSB = 9;
    localparam int PIN_LEVEL_LSB = 0;
    localparam int IRQ_PULLUP_BIT = 7;
    localparam int HIGH_GROUP_DRIVE_LSB = 8;
    localparam int CLKO_DRIVE_LSB = 10;
    localparam int IRQ_DRIVE_LSB = 12;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [15:0] DOZE_CTL_RESET = 16'h0000;
    localparam logic [15:0] DOZE_CTL_MASK = 16'h0203;
    localparam logic [15:0] MISC_CTL_RESET = 16'h0020;
    localparam logic [15:0] MISC_CTL_MASK = 16'h00a0;
    localparam logic [15:0] CLKO_CTL_RESET = 16'h0006;
    localparam logic [15:0] CLKO_CTL_MASK = 16'hff07;
    localparam logic [15:0] PIN_DIR_RESET = 16'hfe00;
    localparam logic [15:0] PIN_DIR_MASK = 16'hffff;
    localparam logic [15:0] PIN_OUT_RESET = 16'h3080;
    localparam logic [15:0] PIN_OUT_MASK = 16'h3fff;

    // ==========================================================
    // Clock-out rate codes and timing
    localparam logic [2:0] RATE_32K = 3'h6;
    localparam logic [2:0] RATE_16K = 3'h7;
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int REF_CLK_MHZ = 16;
    localparam int DOZE_STOP_REF_CYCLES = 128;
    localparam int DOZE_STOP_NS = DOZE_STOP_REF_CYCLES * 1000 / REF_CLK_MHZ;
    localparam int DOZE_STOP_CYCLES =
        (DOZE_STOP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // Output frequency of each rate code in hertz
    function automatic int clko_hz(input logic [2:0] code);
        unique case (code)
            3'h0: clko_hz = 16_000_000;
            3'h1: clko_hz = 8_000_000;
            3'h2: clko_hz = 4_000_000;
            3'h3: clko_hz = 2_000_000;
            3'h4: clko_hz = 1_000_000;
            3'h5: clko_hz = 500_000;
            3'h6: clko_hz = 32_768;
            3'h7: clko_hz = 16_384;
        endcase
    endfunction

    // Half period in system clocks, never below one
    function automatic int clko_half(input logic [2:0] code);
        int h;
        h = SYS_CLK_HZ / (2 * clko_hz(code));
        clko_half = (h < 1) ? 1 : h;
    endfunction

endpackage

// >>> rtl/pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic outEnBit,
    input wire logic inEnBit,
    input wire logic levelBit,
    input wire logic altSel,
    input wire logic altLevel,
    input wire logic padIn,
    output logic padOut,
    output logic padOe_n,
    output logic sampled
);

    // ==========================================================
    // Direction and level
    wire logic driveOn = outEnBit & ~inEnBit; // [RQ5]
    wire logic levelNext = altSel ? altLevel : levelBit; // [RQ7]

    // Driver keeps its level in low-power modes: nothing here gates it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            padOe_n <= 1'b1; // [RQ1]
            padOut <= 1'b0;
            sampled <= 1'b0;
        end else begin
            padOe_n <= ~driveOn; // [RQ3]
            padOut <= levelNext;
            if (inEnBit) begin
                sampled <= padIn; // [RQ8]
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/clock_out_gen.sv
`timescale 1ns/1ps
`default_nettype none

module clock_out_gen #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] rate,
    input wire logic run,
    output logic clkOut
);

    // ==========================================================
    // Divider
    logic [CNT_W-1:0] count_reg;
    wire logic [CNT_W-1:0] halfPeriod =
        CNT_W'(pin_ctl_pkg::clko_half(rate)); // [RQ23]
    wire logic atEdge = (count_reg >= halfPeriod - CNT_W'(1));

    // Stopping parks the output low so a restart begins a full phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
            clkOut <= 1'b0;
        end else if (!run) begin
            count_reg <= '0;
            clkOut <= 1'b0; // [RQ15]
        end else if (atEdge) begin
            count_reg <= '0;
            clkOut <= ~clkOut; // [RQ16]
        end else begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// >>> rtl/radio_pin_and_clock_out_control.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RQ1] Reset turns every pin driver off and leaves all pins as inputs.
// [RQ2] Pin changes never raise an interrupt request.
// [RQ3] Output pins keep driving their level through Doze and Hibernate.
// [RQ4] Per-pin output and input enables; inputs enabled, outputs off at reset.
// [RQ5] Input and output both enabled means input only, driver off.
// [RQ6] Pins one-four and five-seven each share a 2-bit drive field.
// [RQ7] Each pin's level bit sets the driven level when output.
// [RQ8] Read-only input register returns each input pin's present state.
// [RQ9] Status select drives pin one high while a sequence runs.
// [RQ10] Status pin one stays low in Doze and Hibernate.
// [RQ11] Pin one falling after receive latches CRC result onto pin two.
// [RQ12] Pin one falling after CCA latches CCA result onto pin two.
// [RQ13] Host ignores pin two after an aborted sequence.
// [RQ14] Host sets pins one and two as outputs for status function.
// [RQ15] Clock output toggles only while enable bit 5 is set; resets set.
// [RQ16] Three-bit rate field picks 16 MHz to 16 kHz; resets to 110.
// [RQ17] Keep-in-Doze bit set at Doze entry keeps clock output running.
// [RQ18] Otherwise clock output stops 128 reference cycles after Doze request.
// [RQ19] Clock restarts on Doze exit, except two lowest rates need re-enable.
// [RQ20] Clock-out drive in output register bits 11-10, reset 00.
// [RQ21] Host picks drive strength to suit the clock-out rate.
// [RQ22] Status read or software-reset write restores configuration defaults.
// [RQ23] Rate codes are successive divisions; 000 is the fastest.
module radio_pin_and_clock_out_control #(
    parameter int NUM_PINS = pin_ctl_pkg::NUM_PINS,
    parameter int STOP_CYCLES = pin_ctl_pkg::DOZE_STOP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic seqActive,
    input wire logic seqIsRx,
    input wire logic seqIsCca,
    input wire logic crcValid,
    input wire logic ccaResult,
    input wire logic dozeWake,
    input wire logic hibernateWake,
    input wire logic [6:0] pinIn,
    output logic [6:0] pinOut,
    output logic [6:0] pinOe_n,
    output logic [1:0] lowGroupDrive,
    output logic [1:0] highGroupDrive,
    output logic clkOut,
    output logic [1:0] clkOutDrive,
    output logic dozeMode,
    output logic hibernateMode
);

    // ==========================================================
    // Configuration registers
    logic [15:0] dozeCtl_reg;
    logic [15:0] miscCtl_reg;
    logic [15:0] clkoCtl_reg;
    logic [15:0] pinDir_reg;
    logic [15:0] pinOutVal_reg;
    logic [15:0] dozeCtl_next;
    logic [15:0] miscCtl_next;
    logic [15:0] clkoCtl_next;
    logic [15:0] pinDir_next;
    logic [15:0] pinOutVal_next;

    // ==========================================================
    // Address decode
    wire logic wrDoze = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_DOZE_CLOCK_CONTROL;
    wire logic wrMisc = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_MISC_CONTROL;
    wire logic wrClko = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_CLOCK_OUT_CONTROL;
    wire logic wrDir = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_PIN_DIRECTION;
    wire logic wrOut = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_PIN_OUTPUT_VALUE;
    wire logic wrReset = regWrite &&
        regAddr == pin_ctl_pkg::ADDR_SW_RESET;
    wire logic rdIrq = regRead &&
        regAddr == pin_ctl_pkg::ADDR_IRQ_STATUS;
    wire logic softClear = wrReset | rdIrq; // [RQ22]

    // ==========================================================
    // Field views
    wire logic clkoEn = miscCtl_reg[pin_ctl_pkg::CLKO_EN_BIT]; // [RQ15]
    wire logic statusSel = miscCtl_reg[pin_ctl_pkg::STATUS_PIN_SEL_BIT];
    wire logic keepInDoze = dozeCtl_reg[pin_ctl_pkg::KEEP_IN_DOZE_BIT];
    wire logic [2:0] clkoRate =
        clkoCtl_reg[pin_ctl_pkg::CLKO_RATE_LSB +: 3]; // [RQ16]
    wire logic [6:0] pinOutEn =
        pinDir_reg[pin_ctl_pkg::PIN_OEN_LSB +: 7]; // [RQ4]
    wire logic [6:0] pinInEn =
        pinDir_reg[pin_ctl_pkg::PIN_IEN_LSB +: 7]; // [RQ4]
    wire logic [6:0] pinLevel =
        pinOutVal_reg[pin_ctl_pkg::PIN_LEVEL_LSB +: 7]; // [RQ7]

    // ==========================================================
    // Low-power request bits; hardware clears them on wake-up
    wire logic dozeReqWr = wrDoze && regWrData[pin_ctl_pkg::DOZE_REQ_BIT];
    wire logic dozeExit = dozeMode && dozeWake;
    wire logic hibExit = hibernateMode && hibernateWake;

    always_comb begin
        dozeCtl_next = dozeCtl_reg;
        if (wrDoze) begin
            dozeCtl_next = regWrData & pin_ctl_pkg::DOZE_CTL_MASK;
        end else begin
            if (dozeExit) begin
                dozeCtl_next[pin_ctl_pkg::DOZE_REQ_BIT] = 1'b0;
            end
            if (hibExit) begin
                dozeCtl_next[pin_ctl_pkg::HIBERNATE_REQ_BIT] = 1'b0;
            end
        end
    end

    assign miscCtl_next = wrMisc ?
        (regWrData & pin_ctl_pkg::MISC_CTL_MASK) : miscCtl_reg;
    assign clkoCtl_next = wrClko ?
        (regWrData & pin_ctl_pkg::CLKO_CTL_MASK) : clkoCtl_reg;
    assign pinDir_next = wrDir ?
        (regWrData & pin_ctl_pkg::PIN_DIR_MASK) : pinDir_reg;
    assign pinOutVal_next = wrOut ?
        (regWrData & pin_ctl_pkg::PIN_OUT_MASK) : pinOutVal_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dozeCtl_reg <= pin_ctl_pkg::DOZE_CTL_RESET; // [RQ17]
            miscCtl_reg <= pin_ctl_pkg::MISC_CTL_RESET; // [RQ15]
            clkoCtl_reg <= pin_ctl_pkg::CLKO_CTL_RESET; // [RQ16]
            pinDir_reg <= pin_ctl_pkg::PIN_DIR_RESET; // [RQ4]
            pinOutVal_reg <= pin_ctl_pkg::PIN_OUT_RESET; // [RQ20]
        end else if (softClear) begin
            dozeCtl_reg <= pin_ctl_pkg::DOZE_CTL_RESET; // [RQ22]
            miscCtl_reg <= pin_ctl_pkg::MISC_CTL_RESET;
            clkoCtl_reg <= pin_ctl_pkg::CLKO_CTL_RESET;
            pinDir_reg <= pin_ctl_pkg::PIN_DIR_RESET;
            pinOutVal_reg <= pin_ctl_pkg::PIN_OUT_RESET;
        end else begin
            dozeCtl_reg <= dozeCtl_next;
            miscCtl_reg <= miscCtl_next;
            clkoCtl_reg <= clkoCtl_next;
            pinDir_reg <= pinDir_next;
            pinOutVal_reg <= pinOutVal_next;
        end
    end

    assign dozeMode = dozeCtl_reg[pin_ctl_pkg::DOZE_REQ_BIT];
    assign hibernateMode = dozeCtl_reg[pin_ctl_pkg::HIBERNATE_REQ_BIT];
    wire logic lowPower = dozeMode | hibernateMode;

    // ==========================================================
    // Status indicator on pins one and two
    typedef enum logic [1:0] {SEQ_OTHER, SEQ_RX, SEQ_CCA} seq_kind_t;
    seq_kind_t seqKind_reg;
    logic pinOneStatus_reg;
    logic pinTwoResult_reg;

    wire logic pinOneNext = seqActive & ~lowPower; // [RQ9] [RQ10]
    wire logic seqStart = pinOneNext & ~pinOneStatus_reg;
    wire logic pinOneFall = ~pinOneNext & pinOneStatus_reg;
    wire seq_kind_t startKind = seqIsRx ? SEQ_RX :
        (seqIsCca ? SEQ_CCA : SEQ_OTHER);

    // Result is held until the next sequence; a transmit latches low
    logic pinTwoNext;
    always_comb begin
        pinTwoNext = pinTwoResult_reg;
        if (seqStart) begin
            pinTwoNext = 1'b0;
        end else if (pinOneFall) begin
            unique case (seqKind_reg)
                SEQ_RX: pinTwoNext = crcValid; // [RQ11]
                SEQ_CCA: pinTwoNext = ccaResult; // [RQ12]
                SEQ_OTHER: pinTwoNext = 1'b0;
                default: pinTwoNext = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seqKind_reg <= SEQ_OTHER;
            pinOneStatus_reg <= 1'b0;
            pinTwoResult_reg <= 1'b0;
        end else begin
            pinOneStatus_reg <= pinOneNext;
            pinTwoResult_reg <= pinTwoNext;
            if (seqStart) begin
                seqKind_reg <= startKind;
            end
        end
    end

    // ==========================================================
    // Pin cells; no pin event reaches any interrupt logic
    logic [6:0] pinSampled;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            wire logic altSel = statusSel && (gi < 2);
            wire logic altLevel = (gi == 0) ?
                pinOneStatus_reg : pinTwoResult_reg;
            pin_cell u_pin (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .outEnBit(pinOutEn[gi]),
                .inEnBit(pinInEn[gi]),
                .levelBit(pinLevel[gi]),
                .altSel(altSel),
                .altLevel(altLevel),
                .padIn(pinIn[gi]),
                .padOut(pinOut[gi]),
                .padOe_n(pinOe_n[gi]),
                .sampled(pinSampled[gi])
            ); // [RQ2]
        end
    endgenerate

    // Drive fields are plain register bits
    assign lowGroupDrive =
        pinDir_reg[pin_ctl_pkg::LOW_GROUP_DRIVE_LSB +: 2]; // [RQ6]
    assign highGroupDrive =
        pinOutVal_reg[pin_ctl_pkg::HIGH_GROUP_DRIVE_LSB +: 2]; // [RQ6]
    assign clkOutDrive =
        pinOutVal_reg[pin_ctl_pkg::CLKO_DRIVE_LSB +: 2]; // [RQ20]

    // ==========================================================
    // Clock output gating around Doze
    logic [7:0] stopCount_reg;
    logic stopPending_reg;
    logic clkoStopped_reg;
    logic keepLatched_reg;
    logic needReenable_reg;

    wire logic lowRate = (clkoRate == pin_ctl_pkg::RATE_32K) ||
        (clkoRate == pin_ctl_pkg::RATE_16K);
    wire logic dozeEntry = dozeReqWr && !dozeMode;
    wire logic stopDone = stopPending_reg &&
        (stopCount_reg == 8'(STOP_CYCLES - 1));

    // The keep bit is taken at Doze entry; later writes do not matter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stopCount_reg <= 8'h00;
            stopPending_reg <= 1'b0;
            clkoStopped_reg <= 1'b0;
            keepLatched_reg <= 1'b0;
            needReenable_reg <= 1'b0;
        end else if (softClear) begin
            stopCount_reg <= 8'h00;
            stopPending_reg <= 1'b0;
            clkoStopped_reg <= 1'b0;
            keepLatched_reg <= 1'b0;
            needReenable_reg <= 1'b0;
        end else begin
            if (dozeEntry) begin
                keepLatched_reg <= regWrData[pin_ctl_pkg::KEEP_IN_DOZE_BIT];
                stopPending_reg <= clkoEn &&
                    !regWrData[pin_ctl_pkg::KEEP_IN_DOZE_BIT]; // [RQ17]
                stopCount_reg <= 8'h00;
            end else if (stopDone) begin
                stopPending_reg <= 1'b0;
                clkoStopped_reg <= 1'b1; // [RQ18]
            end else if (stopPending_reg) begin
                stopCount_reg <= stopCount_reg + 8'h01;
            end
            if (dozeExit) begin
                stopPending_reg <= 1'b0;
                clkoStopped_reg <= 1'b0; // [RQ19]
                if (clkoStopped_reg && lowRate) begin
                    needReenable_reg <= 1'b1; // [RQ19]
                end
            end else if (!clkoEn) begin
                needReenable_reg <= 1'b0; // [RQ19]
            end
        end
    end

    wire logic clkoRun = clkoEn && !clkoStopped_reg &&
        !needReenable_reg; // [RQ15]

    clock_out_gen #(
        .CNT_W(16)
    ) u_clko (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rate(clkoRate),
        .run(clkoRun),
        .clkOut(clkOut)
    );

    // ==========================================================
    // Read data, one cycle after the strobe
    logic [15:0] rdMux;
    always_comb begin
        unique case (regAddr)
            pin_ctl_pkg::ADDR_DOZE_CLOCK_CONTROL: rdMux = dozeCtl_reg;
            pin_ctl_pkg::ADDR_MISC_CONTROL: rdMux = miscCtl_reg;
            pin_ctl_pkg::ADDR_CLOCK_OUT_CONTROL: rdMux = clkoCtl_reg;
            pin_ctl_pkg::ADDR_PIN_DIRECTION: rdMux = pinDir_reg;
            pin_ctl_pkg::ADDR_PIN_OUTPUT_VALUE: rdMux = pinOutVal_reg;
            pin_ctl_pkg::ADDR_PIN_INPUT_VALUE:
                rdMux = {9'h000, pinSampled & pinInEn}; // [RQ8]
            default: rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 16'h0000;
        end else if (regRead) begin
            regRdData <= rdMux;
        end
    end

endmodule

`default_nettype wire

// >>> test/pin_ctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pin_ctl_monitor #(
    parameter int STOP_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    input wire logic seqActive,
    input wire logic [6:0] pinOut,
    input wire logic [6:0] pinOe_n,
    input wire logic [1:0] lowGroupDrive,
    input wire logic [1:0] highGroupDrive,
    input wire logic clkOut,
    input wire logic [1:0] clkOutDrive,
    input wire logic dozeMode,
    input wire logic hibernateMode
);
    // ==========================================================
    // Shadow of the status select and the Doze stop timer
    logic statusSel_reg;
    logic [15:0] stopCnt_reg;
    wire logic cfgClear = (regWrite && regAddr == 6'h00)
        || (regRead && regAddr == 6'h24);
    wire logic stopEntry = regWrite && regAddr == 6'h07 && regWrData[1]
        && !regWrData[9] && !dozeMode;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            statusSel_reg <= 1'b0;
        end else if (cfgClear) begin
            statusSel_reg <= 1'b0;
        end else if (regWrite && regAddr == 6'h09) begin
            statusSel_reg <= regWrData[7];
        end
    end
    // Saturates so a long Doze never wraps back below the limit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stopCnt_reg <= '0;
        end else if (stopEntry) begin
            stopCnt_reg <= 16'h0001;
        end else if (!dozeMode || cfgClear) begin
            stopCnt_reg <= '0;
        end else if (stopCnt_reg != '0 && stopCnt_reg != '1) begin
            stopCnt_reg <= stopCnt_reg + 16'h0001;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    reset_drivers_off_a: assert property (
        disable iff (1'b0) !nrst |-> pinOe_n == 7'h7f)
        else $error("pin driver on during reset");
    irq_read_zero_a: assert property (
        regRead && regAddr == 6'h24 |=> regRdData == 16'h0000)
        else $error("status read not zero");
    soft_reset_a: assert property (
        regWrite && regAddr == 6'h00 |-> ##3 (pinOe_n == 7'h7f
        && lowGroupDrive == 2'h0 && highGroupDrive == 2'h0
        && clkOutDrive == 2'h0))
        else $error("soft reset left pin settings");
    dir_enable_a: assert property (
        regWrite && regAddr == 6'h0b ##1 !(regWrite || regRead) [*3]
        |-> pinOe_n == ~($past(regWrData[6:0], 3)
        & ~$past(regWrData[15:9], 3)))
        else $error("driver enable mismatch");
    out_level_a: assert property (
        regWrite && regAddr == 6'h0c ##1 !(regWrite || regRead) [*3]
        |-> ((pinOut[6:2] ^ $past(regWrData[6:2], 3)) & ~pinOe_n[6:2])
        == 5'h00)
        else $error("driven level mismatch");
    group_drive_a: assert property (
        regWrite && regAddr == 6'h0c
        |=> highGroupDrive == $past(regWrData[9:8])
        && clkOutDrive == $past(regWrData[11:10]))
        else $error("drive field mismatch");
    doze_clock_stop_a: assert property (
        int'(stopCnt_reg) > STOP_CYCLES + 2 |-> !clkOut)
        else $error("clock out running in Doze");
    busy_pin_high_a: assert property (
        (statusSel_reg && seqActive && !dozeMode && !hibernateMode) [*3]
        |-> pinOut[0])
        else $error("busy pin low while busy");
    busy_pin_idle_a: assert property (
        (statusSel_reg && !seqActive) [*3] |-> !pinOut[0])
        else $error("busy pin high while idle");
    busy_pin_doze_a: assert property (
        (statusSel_reg && (dozeMode || hibernateMode)) [*3] |-> !pinOut[0])
        else $error("busy pin high in low power");
endmodule
`default_nettype wire

// >>> test/pin_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
    input wire logic [6:0] pinOut,
    input wire logic [6:0] pinOe_n,
    input wire logic [6:0] boardLevel,
    output logic [6:0] pinIn
);
    // A driving pin wins; released pins show the board source
    assign pinIn = (pinOut & ~pinOe_n) | (boardLevel & pinOe_n);
endmodule
`default_nettype wire

// >>> test/radio_pin_and_clock_out_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module radio_pin_and_clock_out_control_tb_top;
    // Short Doze stop keeps the run brief
    localparam int STOP = 4;
    localparam logic [5:0] RA [6] = '{6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0c,
        6'h3f};
    localparam logic [15:0] RV [6] = '{16'h0000, 16'h0020, 16'h0006,
        16'hfe00, 16'h3080, 16'h0000};
    logic sys_clk = 1'b0;
    logic nrst = 1'b1;
    logic [5:0] regAddr = 6'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic seqActive = 1'b0, seqIsRx = 1'b0, seqIsCca = 1'b0;
    logic crcValid = 1'b0, ccaResult = 1'b0, dozeWake = 1'b0;
    logic hibernateWake = 1'b0;
    logic [6:0] boardLevel = 7'h00;
    logic [15:0] regRdData, rdv, d, o;
    logic [6:0] pinIn, pinOut, pinOe_n, e;
    logic [1:0] lowGroupDrive, highGroupDrive, clkOutDrive;
    logic clkOut, dozeMode, hibernateMode;
    int err_count = 0;
    int compares = 0;
    int t, h;
    always #20 sys_clk = ~sys_clk;
    radio_pin_and_clock_out_control #(.STOP_CYCLES(STOP)) DUT (.*);
    pin_board_model board (.*);
    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = v;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        @(negedge sys_clk);
        rdv = regRdData;
    endtask
    task automatic toggles(input int n);
        logic p;
        t = 0;
        p = clkOut;
        repeat (n) begin
            @(negedge sys_clk);
            if (clkOut !== p) t++;
            p = clkOut;
        end
    endtask
    task automatic wake(input logic hib);
        @(negedge sys_clk);
        {dozeWake, hibernateWake} = {!hib, hib};
        @(negedge sys_clk);
        {dozeWake, hibernateWake} = 2'b00;
    endtask
    // Opposite results on the unused source catch a swapped select
    task automatic seq(input logic rx, input logic cca, input logic res);
        @(negedge sys_clk);
        seqIsRx = rx;
        seqIsCca = cca;
        seqActive = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(pinOut[1:0], 2'h1);
        crcValid = rx ? res : !res;
        ccaResult = rx ? !res : res;
        seqActive = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(pinOut[1:0], {(rx || cca) && res, 1'b0});
    endtask
    task automatic give_verdict();
        $display("Mismatches %0d of %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 40);
        err_count++;
        give_verdict();
    end
    // ==========================================================
    // Main sequence
    initial begin
        #1 nrst = 1'b0;
        void'($urandom(32'ha68b3f5c));
        repeat (6) @(negedge sys_clk);
        chk(pinOe_n, 7'h7f);
        nrst = 1'b1;
        foreach (RA[i]) begin
            rd(RA[i]);
            chk(rdv, RV[i]);
        end
        repeat (12) begin
            d = 16'($urandom());
            o = 16'($urandom()) & 16'h3fff;
            boardLevel = 7'($urandom());
            e = d[6:0] & ~d[15:9];
            wr(6'h0c, o);
            wr(6'h28, 16'hffff);
            wr(6'h0b, d);
            repeat (3) @(negedge sys_clk);
            chk(pinOe_n, 7'(~e));
            chk(pinOut & e, o[6:0] & e);
            rd(6'h28);
            chk(rdv, {9'h000, d[15:9] & boardLevel});
            rd(6'h0b);
            chk(rdv, d);
            chk({lowGroupDrive, highGroupDrive, clkOutDrive},
                {d[8:7], o[9:8], o[11:10]});
        end
        wr(6'h0b, 16'h007f);
        wr(6'h0c, 16'h0c55);
        repeat (4) @(negedge sys_clk);
        for (int c = 0; c < 6; c++) begin
            wr(6'h0a, 16'(c));
            toggles(60);
            toggles(200);
            h = 25000000 / (2 * (16000000 >> c));
            h = (h < 1) ? 1 : h;
            chk(t >= 200 / h - 1 && t <= 200 / h + 1, 1'b1);
        end
        wr(6'h09, 16'h0000);
        toggles(60);
        toggles(200);
        chk(t, 0);
        wr(6'h09, 16'h0020);
        wr(6'h0a, 16'h0004);
        wr(6'h07, 16'h0002);
        toggles(STOP + 4);
        toggles(100);
        chk(t, 0);
        chk(pinOut, 7'h55);
        wake(1'b0);
        toggles(100);
        chk(t > 0, 1'b1);
        wr(6'h07, 16'h0202);
        toggles(100);
        chk(t > 0, 1'b1);
        wake(1'b0);
        wr(6'h0a, 16'h0007);
        wr(6'h07, 16'h0002);
        toggles(STOP + 4);
        wake(1'b0);
        toggles(1600);
        chk(t, 0);
        wr(6'h09, 16'h0000);
        wr(6'h09, 16'h0020);
        toggles(1600);
        chk(t > 0, 1'b1);
        wr(6'h07, 16'h0001);
        repeat (4) @(negedge sys_clk);
        chk(pinOut, 7'h55);
        wake(1'b1);
        wr(6'h0b, 16'h0003);
        wr(6'h09, 16'h00a0);
        for (int k = 0; k < 6; k++) begin
            seq(k < 2, k == 2 || k == 3, k % 2 == 0);
        end
        wr(6'h07, 16'h0002);
        seqActive = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk(pinOut[0], 1'b0);
        seqActive = 1'b0;
        wake(1'b0);
        rd(6'h24);
        chk(rdv, 16'h0000);
        rd(6'h09);
        chk(rdv, 16'h0020);
        wr(6'h0b, 16'h007f);
        wr(6'h00, 16'h1234);
        repeat (3) @(negedge sys_clk);
        chk(pinOe_n, 7'h7f);
        give_verdict();
    end
endmodule
bind radio_pin_and_clock_out_control pin_ctl_monitor #(
    .STOP_CYCLES(STOP_CYCLES)
) mon (.*);
`default_nettype wire
